// ### asrx_defs.vh
// Register map, field layout, reset values and limits of the serial receiver channel.
`ifndef ASRX_DEFS_VH
`define ASRX_DEFS_VH

`define ASRX_OFS_CLKSEL_0 32'hffff_f32c
`define ASRX_OFS_DIVISOR_0 32'hffff_f32e
`define ASRX_OFS_CLKSEL_1 32'hffff_f34c
`define ASRX_OFS_DIVISOR_1 32'hffff_f34e
`define ASRX_OFS_MODE_0 32'hffff_f320
`define ASRX_OFS_ERRSTAT_0 32'hffff_f322
`define ASRX_OFS_RXBUF_0 32'hffff_f324
`define ASRX_OFS_STATUS_0 32'hffff_f326
`define ASRX_OFS_MODE_1 32'hffff_f340
`define ASRX_OFS_ERRSTAT_1 32'hffff_f342
`define ASRX_OFS_RXBUF_1 32'hffff_f344
`define ASRX_OFS_STATUS_1 32'hffff_f346

`define ASRX_CLKSEL_RST 4'h0
`define ASRX_DIVISOR_RST 8'hff
`define ASRX_MODE_RST 8'h40

`define ASRX_MODE_UNIT_EN 0
`define ASRX_MODE_TX_EN 1
`define ASRX_MODE_RX_EN 2
`define ASRX_MODE_MERGE 3
`define ASRX_MODE_PAR_LO 4
`define ASRX_MODE_PAR_HI 5
`define ASRX_MODE_CHAR8 6
`define ASRX_MODE_STOP2 7

`define ASRX_PAR_NONE 2'h0
`define ASRX_PAR_ZERO 2'h1
`define ASRX_PAR_ODD 2'h2
`define ASRX_PAR_EVEN 2'h3

`define ASRX_ERR_PARITY 0
`define ASRX_ERR_FRAMING 1
`define ASRX_ERR_OVERRUN 2

`define ASRX_STAT_BUF_FULL 0
`define ASRX_STAT_BUSY 1

`define ASRX_PRESCALE_MAX 4'ha
`define ASRX_DIVISOR_MIN 8'h08

`endif

// ### asrx_brg.v
// Eight-bit programmable divide counter of the baud generator.
`timescale 1ns/1ps
module asrx_brg #(
  parameter P_W = 8
)
(
  input wire i_clk,
  input wire i_srst,
  input wire i_run,
  input wire i_tick,
  input wire [P_W-1:0] i_divisor,
  output reg o_match
);

  reg [P_W-1:0] cnt_r;

  // Held cleared while not running, so every frame starts from a known phase.
  always @(posedge i_clk)
  begin
    if (i_srst || !i_run)
    begin
      cnt_r <= {P_W{1'b0}};
      o_match <= 1'b0;
    end
    else if (i_tick)
    begin
      if (cnt_r == i_divisor - 1'b1)
      begin
        cnt_r <= {P_W{1'b0}};
        o_match <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
        o_match <= 1'b0;
      end
    end
    else
    begin
      o_match <= 1'b0;
    end
  end

endmodule // asrx_brg

// ### asrx_top.v
// Asynchronous serial receive channel with its baud generator and register slave.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "asrx_defs.vh"

module asrx_top #(
  parameter P_CH = 0,
  parameter P_AW = 32
)
(
  input wire i_clk,
  input wire i_srst,
  input wire [P_AW-1:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  output reg [31:0] o_readdata,
  output wire o_waitrequest,
  input wire i_serial_in_pin,
  output reg o_rx_done_irq,
  output reg o_rx_error_irq,
  output reg o_tx_baud_tick
);

  localparam [P_AW-1:0] L_OFS_CLKSEL = (P_CH == 0) ? `ASRX_OFS_CLKSEL_0 : `ASRX_OFS_CLKSEL_1;
  localparam [P_AW-1:0] L_OFS_DIVISOR = (P_CH == 0) ? `ASRX_OFS_DIVISOR_0 : `ASRX_OFS_DIVISOR_1;
  localparam [P_AW-1:0] L_OFS_MODE = (P_CH == 0) ? `ASRX_OFS_MODE_0 : `ASRX_OFS_MODE_1;
  localparam [P_AW-1:0] L_OFS_ERRSTAT = (P_CH == 0) ? `ASRX_OFS_ERRSTAT_0 : `ASRX_OFS_ERRSTAT_1;
  localparam [P_AW-1:0] L_OFS_RXBUF = (P_CH == 0) ? `ASRX_OFS_RXBUF_0 : `ASRX_OFS_RXBUF_1;
  localparam [P_AW-1:0] L_OFS_STATUS = (P_CH == 0) ? `ASRX_OFS_STATUS_0 : `ASRX_OFS_STATUS_1;

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_DATA = 3'h2;
  localparam [2:0] S_PARITY = 3'h3;
  localparam [2:0] S_STOP = 3'h4;

  // Prescaler mask: a tick is produced when the low bits of the free counter are all ones.
  function [9:0] f_pre_mask;
    input [3:0] sel;
    reg [3:0] s;
    begin
      s = (sel > `ASRX_PRESCALE_MAX) ? `ASRX_PRESCALE_MAX : sel;
      f_pre_mask = 10'h3ff >> (4'ha - s);
    end
  endfunction

  reg ack_r;
  reg [3:0] clksel_r;
  reg [7:0] divisor_r;
  reg [7:0] mode_r;
  reg [2:0] err_r;
  reg [2:0] err_nxt;
  reg [7:0] rxbuf_r;
  reg buf_full_r;
  reg [9:0] pre_cnt_r;
  reg basic_tick_r;
  reg samp_a_r;
  reg filt_r;
  reg filt_d_r;
  reg [2:0] state_r;
  reg skip_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg par_acc_r;
  reg par_err_r;
  reg tx_half_r;
  reg [7:0] rd_mux;
  reg frame_done;
  reg [7:0] frame_data;
  reg pe_now;
  reg fe_now;
  reg ove_now;

  wire unit_en = mode_r[`ASRX_MODE_UNIT_EN];
  wire tx_en = mode_r[`ASRX_MODE_TX_EN];
  wire rx_en = mode_r[`ASRX_MODE_RX_EN];
  wire merge = mode_r[`ASRX_MODE_MERGE];
  wire [1:0] par_mode = mode_r[`ASRX_MODE_PAR_HI:`ASRX_MODE_PAR_LO];
  wire char8 = mode_r[`ASRX_MODE_CHAR8];
  wire rx_on = unit_en && rx_en;
  wire req = i_read || i_write;
  wire wr_fire = i_write && ack_r && i_byteenable[0];
  wire rd_fire = i_read && ack_r;
  wire rx_match;
  wire tx_match;
  wire [2:0] last_bit = char8 ? 3'h7 : 3'h6;

  // Every request is held one cycle, then accepted on the second edge.
  assign o_waitrequest = req && !ack_r;

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= req && !ack_r;
    end
  end

  always @*
  begin
    if (i_address == L_OFS_CLKSEL)
    begin
      rd_mux = {4'h0, clksel_r};
    end
    else if (i_address == L_OFS_DIVISOR)
    begin
      rd_mux = divisor_r;
    end
    else if (i_address == L_OFS_MODE)
    begin
      rd_mux = mode_r;
    end
    else if (i_address == L_OFS_ERRSTAT)
    begin
      rd_mux = {5'h00, err_r};
    end
    else if (i_address == L_OFS_RXBUF)
    begin
      rd_mux = rxbuf_r;
    end
    else if (i_address == L_OFS_STATUS)
    begin
      rd_mux = {6'h00, (state_r != S_IDLE), buf_full_r};
    end
    else
    begin
      rd_mux = 8'h00;
    end
  end

  // Read data is captured in the waiting cycle, so it stands at the accepting edge.
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_readdata <= 32'h0000_0000;
    end
    else if (i_read && !ack_r)
    begin
      o_readdata <= {24'h00_0000, rd_mux};
    end
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      clksel_r <= `ASRX_CLKSEL_RST;
      divisor_r <= `ASRX_DIVISOR_RST;
      mode_r <= `ASRX_MODE_RST;
    end
    else if (wr_fire)
    begin
      if (i_address == L_OFS_CLKSEL)
      begin
        clksel_r <= i_writedata[3:0];
      end
      if (i_address == L_OFS_DIVISOR)
      begin
        // Values below the minimum are raised to it, keeping the half-bit at least four times the two-tick filter lag.
        divisor_r <= (i_writedata[7:0] < `ASRX_DIVISOR_MIN) ? `ASRX_DIVISOR_MIN : i_writedata[7:0];
      end
      if (i_address == L_OFS_MODE)
      begin
        mode_r <= i_writedata[7:0];
      end
    end
  end

  // Basic clock as a one-cycle tick; held low while the unit is disabled.
  always @(posedge i_clk)
  begin
    if (i_srst || !unit_en)
    begin
      pre_cnt_r <= 10'h000;
      basic_tick_r <= 1'b0;
    end
    else
    begin
      pre_cnt_r <= pre_cnt_r + 10'h001;
      basic_tick_r <= ((pre_cnt_r & f_pre_mask(clksel_r)) == f_pre_mask(clksel_r));
    end
  end

  // The line must equal the last tick's sample, so one-tick pulses are dropped and the lag stays at two ticks.
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      samp_a_r <= 1'b1;
      filt_r <= 1'b1;
      filt_d_r <= 1'b1;
    end
    else
    begin
      filt_d_r <= filt_r;
      if (basic_tick_r)
      begin
        samp_a_r <= i_serial_in_pin;
        if (i_serial_in_pin == samp_a_r)
        begin
          filt_r <= samp_a_r;
        end
      end
    end
  end

  asrx_brg #(
    .P_W(8)
  ) u_rx_brg (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(rx_on && (state_r != S_IDLE)),
    .i_tick(basic_tick_r),
    .i_divisor(divisor_r),
    .o_match(rx_match)
  );

  asrx_brg #(
    .P_W(8)
  ) u_tx_brg (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(unit_en && tx_en),
    .i_tick(basic_tick_r),
    .i_divisor(divisor_r),
    .o_match(tx_match)
  );

  always @(posedge i_clk)
  begin
    if (i_srst || !(unit_en && tx_en))
    begin
      tx_half_r <= 1'b0;
      o_tx_baud_tick <= 1'b0;
    end
    else
    begin
      if (tx_match)
      begin
        tx_half_r <= !tx_half_r;
      end
      o_tx_baud_tick <= tx_match && tx_half_r;
    end
  end

  // Receive sequencer: first match is mid start bit, then every second match is mid bit.
  always @(posedge i_clk)
  begin
    if (i_srst || !rx_on)
    begin
      state_r <= S_IDLE;
      skip_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      par_acc_r <= 1'b0;
      par_err_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          if (filt_d_r && !filt_r)
          begin
            state_r <= S_START;
          end
        end
        S_START:
        begin
          if (rx_match)
          begin
            state_r <= filt_r ? S_IDLE : S_DATA;
            skip_r <= 1'b1;
            bit_cnt_r <= 3'h0;
            par_acc_r <= 1'b0;
            par_err_r <= 1'b0;
          end
        end
        default:
        begin
          if (rx_match)
          begin
            skip_r <= !skip_r;
            if (!skip_r)
            begin
              case (state_r)
                S_DATA:
                begin
                  shift_r <= {filt_r, shift_r[7:1]};
                  par_acc_r <= par_acc_r ^ filt_r;
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == last_bit)
                  begin
                    state_r <= (par_mode == `ASRX_PAR_NONE) ? S_STOP : S_PARITY;
                  end
                end
                S_PARITY:
                begin
                  if (par_mode == `ASRX_PAR_EVEN)
                  begin
                    par_err_r <= par_acc_r ^ filt_r;
                  end
                  else if (par_mode == `ASRX_PAR_ODD)
                  begin
                    par_err_r <= !(par_acc_r ^ filt_r);
                  end
                  else
                  begin
                    par_err_r <= 1'b0;
                  end
                  state_r <= S_STOP;
                end
                default:
                begin
                  state_r <= S_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always @*
  begin
    frame_done = rx_on && (state_r == S_STOP) && rx_match && !skip_r;
    frame_data = char8 ? shift_r : {1'b0, shift_r[7:1]};
    pe_now = frame_done && par_err_r;
    fe_now = frame_done && !filt_r;
    ove_now = frame_done && buf_full_r;
    err_nxt = err_r;
    if (rd_fire && (i_address == L_OFS_ERRSTAT))
    begin
      err_nxt = 3'h0;
    end
    // A new error in the clearing cycle survives the clear.
    if (pe_now)
    begin
      err_nxt[`ASRX_ERR_PARITY] = 1'b1;
    end
    if (fe_now)
    begin
      err_nxt[`ASRX_ERR_FRAMING] = 1'b1;
    end
    if (ove_now)
    begin
      err_nxt[`ASRX_ERR_OVERRUN] = 1'b1;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      err_r <= 3'h0;
      rxbuf_r <= 8'h00;
      buf_full_r <= 1'b0;
      o_rx_done_irq <= 1'b0;
      o_rx_error_irq <= 1'b0;
    end
    else
    begin
      err_r <= err_nxt;
      if (frame_done && !buf_full_r)
      begin
        rxbuf_r <= frame_data;
        buf_full_r <= 1'b1;
      end
      else if (rd_fire && (i_address == L_OFS_RXBUF))
      begin
        buf_full_r <= 1'b0;
      end
      o_rx_done_irq <= frame_done && (merge || !(pe_now || fe_now || ove_now));
      o_rx_error_irq <= frame_done && !merge && (pe_now || fe_now || ove_now);
    end
  end

endmodule // asrx_top

// ### asrx_top_asserts.sv
// Checker of bus, interrupt and tick timing of the receive channel.
`timescale 1ns/1ps
`include "asrx_defs.vh"
module asrx_chk #(
  parameter P_AW = 32
)
(
  input wire i_clk,
  input wire i_srst,
  input wire [P_AW-1:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  input wire [31:0] o_readdata,
  input wire o_waitrequest,
  input wire i_serial_in_pin,
  input wire o_rx_done_irq,
  input wire o_rx_error_irq,
  input wire o_tx_baud_tick
);
  reg [7:0] low_r;
  reg clean_r;
  wire irq = o_rx_done_irq || o_rx_error_irq;
  wire acc = i_read && !o_waitrequest;
  wire es = i_address == `ASRX_OFS_ERRSTAT_0;
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      low_r <= 8'hff;
      clean_r <= 1'b0;
    end
    else
    begin
      low_r <= !i_serial_in_pin ? 8'h00 : (low_r == 8'hff ? low_r : low_r + 8'h01);
      clean_r <= irq ? 1'b0 : ((acc && es) ? 1'b1 : clean_r);
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  chk_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus answer late");
  chk_clksel_hi: assert property (acc && i_address == `ASRX_OFS_CLKSEL_0 |-> o_readdata[31:4] == 0)
    else $error("clock select upper bits set");
  chk_done_pulse: assert property (o_rx_done_irq |=> !o_rx_done_irq)
    else $error("done pulse too long");
  chk_err_pulse: assert property (o_rx_error_irq |=> !o_rx_error_irq)
    else $error("error pulse too long");
  chk_irq_excl: assert property (!(o_rx_done_irq && o_rx_error_irq))
    else $error("both interrupts raised");
  chk_start_seen: assert property (irq |-> low_r <= 8'd220)
    else $error("interrupt without start bit");
  chk_tick_gap: assert property (o_tx_baud_tick |=> !o_tx_baud_tick [*8])
    else $error("baud tick too close");
  chk_err_clear: assert property (acc && es && clean_r && !irq |-> o_readdata == 0)
    else $error("error status not cleared");
  cover property (o_rx_done_irq);
  cover property (o_rx_error_irq);
  cover property (o_tx_baud_tick);
endmodule // asrx_chk

// ### asrx_tx_model.sv
// Remote transmitter model driving the serial line, with fault controls.
`timescale 1ns/1ps
module asrx_tx_model #(
  parameter P_BIT = 16
)
(
  input wire i_clk,
  input wire i_go,
  input wire [7:0] i_data,
  input wire [1:0] i_par,
  input wire i_bad_par,
  input wire i_bad_stop,
  input wire i_glitch,
  output reg o_line,
  output reg o_busy
);
  reg [11:0] sh_r;
  reg [3:0] left_r;
  reg [7:0] cnt_r;
  reg pb;
  initial
  begin
    o_line = 1'b1;
    o_busy = 1'b0;
  end
  always @(posedge i_clk)
  begin
    pb = ^i_data ^ (i_par == 2'h2) ^ i_bad_par;
    if (i_par == 2'h1)
      pb = i_bad_par;
    if (i_go)
    begin
      sh_r <= (i_par == 2'h0) ? {2'h3, ~i_bad_stop, i_data, 1'b0} : {1'b1, ~i_bad_stop, pb, i_data, 1'b0};
      left_r <= (i_par == 2'h0) ? 4'd10 : 4'd11;
      cnt_r <= 8'h00;
      o_busy <= 1'b1;
    end
    else if (o_busy)
    begin
      cnt_r <= (cnt_r == P_BIT - 1) ? 8'h00 : cnt_r + 8'h01;
      if (cnt_r == P_BIT - 1)
      begin
        sh_r <= {1'b1, sh_r[11:1]};
        left_r <= left_r - 4'd1;
        o_busy <= left_r != 4'd1;
      end
    end
    // The idle line is high; a glitch pulls it low for as long as i_glitch is held.
    o_line <= o_busy ? sh_r[0] : !i_glitch;
  end
endmodule // asrx_tx_model

// ### asrx_top_tb.sv
// Self-checking bench of the receive channel against the transmitter model.
`timescale 1ns/1ps
`include "asrx_defs.vh"
module asrx_top_tb;
  localparam CS = `ASRX_OFS_CLKSEL_0;
  localparam DV = `ASRX_OFS_DIVISOR_0;
  localparam MD = `ASRX_OFS_MODE_0;
  localparam ES = `ASRX_OFS_ERRSTAT_0;
  localparam RB = `ASRX_OFS_RXBUF_0;
  localparam ST = `ASRX_OFS_STATUS_0;
  reg i_clk, i_srst, i_read, i_write, go, bpar, bstop, glitch;
  reg [31:0] i_address, i_writedata;
  reg [7:0] tx_d, q;
  reg [1:0] par;
  reg [3:0] be;
  wire [31:0] o_readdata;
  wire o_waitrequest, o_rx_done_irq, o_rx_error_irq, o_tx_baud_tick, line, busy;
  integer err_count, total_checks, n_done, n_err, n_tick, d0, e0, t0, cyc, last, gap, i;
  asrx_top uut (.i_clk(i_clk), .i_srst(i_srst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(be), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_serial_in_pin(line), .o_rx_done_irq(o_rx_done_irq),
    .o_rx_error_irq(o_rx_error_irq), .o_tx_baud_tick(o_tx_baud_tick));
  asrx_tx_model #(.P_BIT(16)) u_tx (.i_clk(i_clk), .i_go(go), .i_data(tx_d), .i_par(par),
    .i_bad_par(bpar), .i_bad_stop(bstop), .i_glitch(glitch), .o_line(line), .o_busy(busy));
  initial
  begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end
  // Outputs are unknown until the first reset edge, so no interrupt or tick is counted during reset; cyc still advances.
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (!i_srst)
    begin
      n_done <= n_done + o_rx_done_irq;
      n_err <= n_err + o_rx_error_irq;
      n_tick <= n_tick + o_tx_baud_tick;
      if (o_tx_baud_tick)
      begin
        gap <= cyc - last;
        last <= cyc;
      end
    end
  end
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  // Waitrequest and read data are taken at the rising edge, before the slave's own updates of that edge land.
  task bus(input w, input [31:0] a, input [7:0] d);
  begin
    @(posedge i_clk);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_writedata <= {24'h0, d};
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0)
      @(posedge i_clk);
    q = o_readdata[7:0];
    i_read <= 1'b0;
    i_write <= 1'b0;
  end
  endtask
  task rd(input [31:0] a, input [7:0] e);
  begin
    bus(0, a, 8'h00);
    chk({24'h0, q}, {24'h0, e});
  end
  endtask
  task kick(input [7:0] d, input bp, input bs);
  begin
    @(posedge i_clk);
    d0 = n_done;
    e0 = n_err;
    tx_d <= d;
    bpar <= bp;
    bstop <= bs;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
  end
  endtask
  task send(input [7:0] d, input bp, input bs);
  begin
    kick(d, bp, bs);
    repeat (220) @(posedge i_clk);
  end
  endtask
  task irq(input [31:0] ed, input [31:0] ee);
  begin
    chk(n_done - d0, ed);
    chk(n_err - e0, ee);
  end
  endtask
  initial
  begin
    i_srst = 1;
    {i_read, i_write, go, bpar, bstop, glitch} = 6'h00;
    be = 4'h1;
    {i_address, i_writedata, tx_d, par} = 0;
    {err_count, total_checks, n_done, n_err, n_tick, cyc, last, gap} = 0;
    repeat (4) @(posedge i_clk);
    i_srst <= 0;
    rd(CS, 8'h00);
    rd(DV, 8'hff);
    bus(1, CS, 8'hff);
    rd(CS, 8'h0f);
    be <= 4'h0;
    bus(1, CS, 8'h05);
    be <= 4'h1;
    rd(CS, 8'h0f);
    rd(ES, 8'h00);
    rd(ES, 8'h00);
    bus(1, CS, 8'h01);
    bus(1, DV, 8'h08);
    bus(1, MD, 8'h43);
    repeat (200) @(posedge i_clk);
    chk(gap, 32);
    bus(1, MD, 8'h42);
    t0 = n_tick;
    repeat (100) @(posedge i_clk);
    chk(n_tick - t0, 0);
    bus(1, CS, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      par <= i;
      bus(1, MD, 8'h47 | (i << 4));
      send(8'ha5, 0, 0);
      irq(1, 0);
      rd(RB, 8'ha5);
      send(8'h3c, 1, 0);
      irq(i < 2, i > 1);
      rd(ES, i > 1);
      rd(RB, 8'h3c);
    end
    par <= 0;
    bus(1, MD, 8'h4f);
    send(8'h81, 0, 1);
    irq(1, 0);
    rd(ES, 8'h02);
    rd(RB, 8'h81);
    bus(1, MD, 8'h47);
    send(8'h11, 0, 0);
    send(8'h22, 0, 0);
    irq(0, 1);
    rd(ST, 8'h01);
    rd(ES, 8'h04);
    rd(RB, 8'h11);
    kick(8'h99, 0, 1);
    repeat (60) @(posedge i_clk);
    bus(1, MD, 8'h43);
    repeat (200) @(posedge i_clk);
    irq(0, 0);
    rd(ES, 8'h00);
    bus(1, MD, 8'h47);
    d0 = n_done;
    e0 = n_err;
    @(posedge i_clk);
    glitch <= 1'b1;
    @(posedge i_clk);
    glitch <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd(ST, 8'h00);
    repeat (300) @(posedge i_clk);
    irq(0, 0);
    send(8'h5a, 0, 0);
    irq(1, 0);
    rd(RB, 8'h5a);
    bus(1, MD, 8'h07);
    send(8'hb5, 0, 0);
    irq(1, 0);
    rd(RB, 8'h35);
    stop_test;
  end
  initial
  begin
    #100000;
    err_count = err_count + 1;
    stop_test;
  end
endmodule // asrx_top_tb
bind asrx_top asrx_chk #(.P_AW(P_AW)) u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_serial_in_pin(i_serial_in_pin),
  .o_rx_done_irq(o_rx_done_irq), .o_rx_error_irq(o_rx_error_irq), .o_tx_baud_tick(o_tx_baud_tick));
